// ### rtl/csmc_pkg.sv
// Package for the clock source mode configuration block.
// Holds register offsets, field positions, reset values and the config record.
// Assumes a decoded serial control port gives byte-wide register accesses.
package csmc_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [9:0] ADDR_PLL_CTRL = 10'h010;
  localparam logic [9:0] ADDR_CAL_CTRL = 10'h018;
  localparam logic [9:0] ADDR_REF_EN = 10'h01c;
  localparam logic [9:0] ADDR_DIV_SET = 10'h1e0;
  localparam logic [9:0] ADDR_SRC_SEL = 10'h1e1;
  localparam logic [9:0] ADDR_UPDATE = 10'h232;
  localparam logic [9:0] ADDR_NV_CTRL = 10'h0b0;

  // ==========================================================================
  // Field positions and encodings
  localparam int unsigned PLL_PWR_LSB = 0;
  localparam int unsigned CP_MODE_LSB = 2;
  localparam int unsigned PFD_POL_BIT = 7;
  localparam int unsigned CAL_BIT = 0;
  localparam int unsigned REF_EN_LSB = 0;
  localparam int unsigned DIV_SEL_LSB = 0;
  localparam int unsigned DIV_BYP_BIT = 0;
  localparam int unsigned SRC_SEL_BIT = 1;
  localparam int unsigned UPDATE_BIT = 0;
  localparam int unsigned NV_SAVE_BIT = 0;
  localparam int unsigned NV_BUSY_BIT = 1;
  localparam int unsigned NV_RESTORED_BIT = 2;
  localparam logic [1:0] PLL_PWR_NORMAL = 2'h0;
  localparam logic [1:0] PLL_PWR_ASYNC_PD = 2'h1;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_PLL_CTRL = 8'h01;
  localparam logic [7:0] RST_CAL_CTRL = 8'h00;
  localparam logic [7:0] RST_REF_EN = 8'h00;
  localparam logic [7:0] RST_DIV_SET = 8'h00;
  localparam logic [7:0] RST_SRC_SEL = 8'h00;

  // ==========================================================================
  // Nonvolatile store layout
  localparam logic [2:0] NV_NUM_BYTES = 3'h5;
  // Arbitrary marker value showing the store holds a saved image
  localparam logic [7:0] NV_SIGNATURE = 8'ha5;

  // Configuration record, one byte per register
  typedef struct packed {
    logic [7:0] pll_ctrl;
    logic [7:0] cal_ctrl;
    logic [7:0] ref_en;
    logic [7:0] div_set;
    logic [7:0] src_sel;
  } csmc_cfg_type;

  localparam csmc_cfg_type CFG_RESET = '{
    pll_ctrl: RST_PLL_CTRL,
    cal_ctrl: RST_CAL_CTRL,
    ref_en: RST_REF_EN,
    div_set: RST_DIV_SET,
    src_sel: RST_SRC_SEL
  };

  // Byte of a config record by index, index 0 is the pll control byte
  function automatic logic [7:0] csmc_cfg_byte(input csmc_cfg_type cfg,
                                              input logic [2:0] idx);
    logic [39:0] flat;
    flat = cfg;
    case (idx)
      3'h0: csmc_cfg_byte = flat[39:32];
      3'h1: csmc_cfg_byte = flat[31:24];
      3'h2: csmc_cfg_byte = flat[23:16];
      3'h3: csmc_cfg_byte = flat[15:8];
      default: csmc_cfg_byte = flat[7:0];
    endcase
  endfunction : csmc_cfg_byte

endpackage : csmc_pkg

// ### rtl/csmc_nv_if.sv
// Interface between the configuration core and its nonvolatile store.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
`default_nettype none
interface csmc_nv_if;
  logic save_req;
  csmc_pkg::csmc_cfg_type save_cfg;
  logic busy;
  logic restored;
  logic restore_done;
  csmc_pkg::csmc_cfg_type restore_cfg;

  modport core (output save_req, output save_cfg, input busy, input restored,
                input restore_done, input restore_cfg);
  modport store (input save_req, input save_cfg, output busy, output restored,
                 output restore_done, output restore_cfg);
endinterface : csmc_nv_if
`default_nettype wire

// ### rtl/csmc_nv_store.sv
// Nonvolatile store for the active configuration image.
// Assumes the array keeps its content across system reset.
`timescale 1ns/10ps
`default_nettype none
module csmc_nv_store (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Core side
  csmc_nv_if.store nv
);

  typedef enum logic [1:0] {CSMC_NV_RESTORE, CSMC_NV_IDLE, CSMC_NV_SAVE} csmc_nv_state_type;

  typedef struct packed {
    csmc_nv_state_type state;
    logic [2:0] idx;
    csmc_pkg::csmc_cfg_type data;
    logic restored;
    logic done;
  } csmc_nv_st_type;

  // ==========================================================================
  // State and storage
  csmc_nv_st_type st_reg;
  csmc_nv_st_type st_next;
  logic [7:0] mem [0:5];
  logic [7:0] rd_byte;

  assign rd_byte = mem[st_reg.idx];

  // Sequencing of save and power-up restore
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    case (st_reg.state)
      CSMC_NV_RESTORE: begin
        if (st_reg.idx == csmc_pkg::NV_NUM_BYTES) begin
          st_next.state = CSMC_NV_IDLE;
          st_next.idx = 3'h0;
          if (rd_byte == csmc_pkg::NV_SIGNATURE) begin
            st_next.done = 1'b1;
            st_next.restored = 1'b1;
          end
        end else begin
          st_next.data = {st_reg.data[31:0], rd_byte};
          st_next.idx = st_reg.idx + 3'h1;
        end
      end
      CSMC_NV_IDLE: begin
        if (nv.save_req) begin
          st_next.state = CSMC_NV_SAVE;
          st_next.data = nv.save_cfg;
          st_next.idx = 3'h0;
        end
      end
      CSMC_NV_SAVE: begin
        if (st_reg.idx == csmc_pkg::NV_NUM_BYTES) begin
          st_next.state = CSMC_NV_IDLE;
          st_next.idx = 3'h0;
        end else begin
          st_next.idx = st_reg.idx + 3'h1;
        end
      end
      default: st_next.state = CSMC_NV_IDLE;
    endcase
  end

  // State register, restore starts right after reset
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_reg <= '{state: CSMC_NV_RESTORE, idx: 3'h0, data: csmc_pkg::CFG_RESET,
                  restored: 1'b0, done: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // Array write, image bytes then marker last
  always_ff @(posedge i_clk_sys) begin
    if (st_reg.state == CSMC_NV_SAVE) begin
      if (st_reg.idx == csmc_pkg::NV_NUM_BYTES) begin
        mem[st_reg.idx] <= csmc_pkg::NV_SIGNATURE;
      end else begin
        mem[st_reg.idx] <= csmc_pkg::csmc_cfg_byte(st_reg.data, st_reg.idx);
      end
    end
  end

  assign nv.busy = (st_reg.state != CSMC_NV_IDLE);
  assign nv.restored = st_reg.restored;
  assign nv.restore_done = st_reg.done;
  assign nv.restore_cfg = st_reg.data;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  property p_save_len;
    (st_reg.state == CSMC_NV_IDLE) && nv.save_req |=> nv.busy [*6] ##1 !nv.busy;
  endproperty
  a_save_len: assert property (p_save_len) else $error("save length wrong");

  property p_restore_window;
    nv.restore_done |-> nv.restored && !nv.busy ##1 !nv.restore_done;
  endproperty
  a_restore_window: assert property (p_restore_window) else $error("restore pulse bad");

endmodule : csmc_nv_store
`default_nettype wire

// ### rtl/csmc_core.sv
// Clock source mode configuration: staged registers, update strobe, mode outputs.
// Assumes a decoded serial control port delivering byte accesses on i_clk_sys.
//
// Notes on behaviour
// - PLL power field 00 runs the PLL, 01 powers it down asynchronously.
// - Source select bit 1 picks internal oscillator, 0 picks external clock.
// - Bypass bit 1 feeds distribution directly, 0 through oscillator divider.
// - Polarity bit 0 is positive detector polarity, 1 is negative.
// - Configuration can be saved to nonvolatile store and restored at power-up.
`timescale 1ns/10ps
`default_nettype none
module csmc_core (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Decoded serial control port
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [9:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rd_valid,
  // PLL controls
  output logic o_pll_normal,
  output logic o_pll_power_down,
  output logic o_pfd_negative,
  output logic [1:0] o_charge_pump_pin_mode,
  output logic [2:0] o_ref_enable,
  // Source and divider routing
  output logic o_src_internal_osc,
  output logic o_div_bypass,
  output logic [2:0] o_osc_div_sel,
  // Calibration
  output logic o_cal_start
);

  typedef struct packed {
    csmc_pkg::csmc_cfg_type staged;
    csmc_pkg::csmc_cfg_type active;
    logic [7:0] rdata;
    logic rd_valid;
    logic cal_start;
    logic save_req;
  } csmc_st_type;

  // ==========================================================================
  // State
  csmc_st_type st_reg;
  csmc_st_type st_next;
  csmc_nv_if nv_bus ();
  logic update_hit;

  csmc_nv_store u_nv_store (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .nv (nv_bus.store)
  );

  // Update strobe write decode
  assign update_hit = i_wr_en && (i_addr == csmc_pkg::ADDR_UPDATE)
                      && i_wdata[csmc_pkg::UPDATE_BIT];

  // Register writes, reads, transfer and calibration trigger
  always_comb begin
    st_next = st_reg;
    st_next.rd_valid = i_rd_en;
    st_next.cal_start = 1'b0;
    st_next.save_req = 1'b0;
    if (i_rd_en) begin
      case (i_addr)
        csmc_pkg::ADDR_PLL_CTRL: st_next.rdata = st_reg.staged.pll_ctrl;
        csmc_pkg::ADDR_CAL_CTRL: st_next.rdata = st_reg.staged.cal_ctrl;
        csmc_pkg::ADDR_REF_EN: st_next.rdata = st_reg.staged.ref_en;
        csmc_pkg::ADDR_DIV_SET: st_next.rdata = st_reg.staged.div_set;
        csmc_pkg::ADDR_SRC_SEL: st_next.rdata = st_reg.staged.src_sel;
        csmc_pkg::ADDR_NV_CTRL: begin
          st_next.rdata = 8'h00;
          st_next.rdata[csmc_pkg::NV_BUSY_BIT] = nv_bus.busy;
          st_next.rdata[csmc_pkg::NV_RESTORED_BIT] = nv_bus.restored;
        end
        default: st_next.rdata = 8'h00;
      endcase
    end
    if (nv_bus.restore_done) begin
      // Power-up image wins over any write in the same cycle
      st_next.staged = nv_bus.restore_cfg;
      st_next.active = nv_bus.restore_cfg;
      st_next.cal_start = nv_bus.restore_cfg.cal_ctrl[csmc_pkg::CAL_BIT];
    end else if (i_wr_en) begin
      case (i_addr)
        csmc_pkg::ADDR_PLL_CTRL: st_next.staged.pll_ctrl = i_wdata;
        csmc_pkg::ADDR_CAL_CTRL: st_next.staged.cal_ctrl = i_wdata;
        csmc_pkg::ADDR_REF_EN: st_next.staged.ref_en = i_wdata;
        csmc_pkg::ADDR_DIV_SET: st_next.staged.div_set = i_wdata;
        csmc_pkg::ADDR_SRC_SEL: st_next.staged.src_sel = i_wdata;
        csmc_pkg::ADDR_UPDATE: begin
          if (update_hit) begin
            st_next.active = st_reg.staged;
            // Start only on a 0 to 1 change of the active calibration bit
            st_next.cal_start = st_reg.staged.cal_ctrl[csmc_pkg::CAL_BIT]
                                && !st_reg.active.cal_ctrl[csmc_pkg::CAL_BIT];
          end
        end
        csmc_pkg::ADDR_NV_CTRL: begin
          // Save request ignored while the store is busy
          st_next.save_req = i_wdata[csmc_pkg::NV_SAVE_BIT] && !nv_bus.busy;
        end
        default: st_next = st_next;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_reg <= '{staged: csmc_pkg::CFG_RESET, active: csmc_pkg::CFG_RESET,
                  rdata: 8'h00, rd_valid: 1'b0, cal_start: 1'b0, save_req: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // Store handshake
  assign nv_bus.save_req = st_reg.save_req;
  assign nv_bus.save_cfg = st_reg.active;

  // Mode outputs decoded from the active configuration
  assign o_pll_normal = st_reg.active.pll_ctrl[csmc_pkg::PLL_PWR_LSB +: 2]
                        == csmc_pkg::PLL_PWR_NORMAL;
  assign o_pll_power_down = st_reg.active.pll_ctrl[csmc_pkg::PLL_PWR_LSB +: 2]
                            == csmc_pkg::PLL_PWR_ASYNC_PD;
  assign o_pfd_negative = st_reg.active.pll_ctrl[csmc_pkg::PFD_POL_BIT];
  assign o_charge_pump_pin_mode = st_reg.active.pll_ctrl[csmc_pkg::CP_MODE_LSB +: 2];
  assign o_ref_enable = st_reg.active.ref_en[csmc_pkg::REF_EN_LSB +: 3];
  assign o_src_internal_osc = st_reg.active.src_sel[csmc_pkg::SRC_SEL_BIT];
  assign o_div_bypass = st_reg.active.src_sel[csmc_pkg::DIV_BYP_BIT];
  assign o_osc_div_sel = st_reg.active.div_set[csmc_pkg::DIV_SEL_LSB +: 3];
  assign o_cal_start = st_reg.cal_start;
  assign o_rdata = st_reg.rdata;
  assign o_rd_valid = st_reg.rd_valid;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  sequence s_update;
    update_hit && !nv_bus.restore_done;
  endsequence

  sequence s_no_transfer;
    !update_hit && !nv_bus.restore_done;
  endsequence

  property p_pll_down;
    s_update |=> o_pll_power_down == ($past(st_reg.staged.pll_ctrl[1:0]) == 2'h1);
  endproperty
  a_pll_down: assert property (p_pll_down) else $error("power-down mismatch");

  property p_pll_normal;
    s_update |=> o_pll_normal == ($past(st_reg.staged.pll_ctrl[1:0]) == 2'h0);
  endproperty
  a_pll_normal: assert property (p_pll_normal) else $error("power field decode bad");

  property p_src_sel;
    s_update |=> o_src_internal_osc == $past(st_reg.staged.src_sel[1]);
  endproperty
  a_src_sel: assert property (p_src_sel) else $error("source select mismatch");

  property p_div_bypass;
    s_update |=> o_div_bypass == $past(st_reg.staged.src_sel[0]);
  endproperty
  a_div_bypass: assert property (p_div_bypass) else $error("bypass mismatch");

  property p_pfd_pol;
    s_update |=> o_pfd_negative == $past(st_reg.staged.pll_ctrl[7]);
  endproperty
  a_pfd_pol: assert property (p_pfd_pol) else $error("polarity mismatch");

  property p_staged_hold;
    s_no_transfer |=> $stable(st_reg.active);
  endproperty
  a_staged_hold: assert property (p_staged_hold) else $error("active changed early");

  property p_cal_start;
    s_update ##0 (st_reg.staged.cal_ctrl[0] && !st_reg.active.cal_ctrl[0])
      |=> o_cal_start ##1 !o_cal_start;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration start missing");

  property p_cal_rearm;
    s_update ##0 st_reg.active.cal_ctrl[0] |=> !o_cal_start;
  endproperty
  a_cal_rearm: assert property (p_cal_rearm) else $error("calibration without rearm");

  property p_save_req;
    i_wr_en && (i_addr == csmc_pkg::ADDR_NV_CTRL) && i_wdata[0] && !nv_bus.busy
      && !nv_bus.restore_done |=> nv_bus.save_req ##1 nv_bus.busy;
  endproperty
  a_save_req: assert property (p_save_req) else $error("save not started");

endmodule : csmc_core
`default_nettype wire

// ### tb/csmc_host_model.sv
// Host controller model driving the decoded register port of the core.
// Assumes the bench calls its tasks; requests change 1 ns after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module csmc_host_model (
  // Clock
  input wire logic i_clk_sys,
  // Register port drive
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [9:0] o_addr,
  output logic [7:0] o_wdata
);
  // ==========================================================================
  // Idle state at time zero
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 10'h000;
    o_wdata = 8'h00;
  end

  // One byte write, strobe held for one taken edge
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    #1;
    o_wr_en = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk_sys);
    #1;
    o_wr_en = 1'b0;
  endtask : wr

  // One byte read request, data is judged by the bench
  task automatic rd(input logic [9:0] a);
    @(posedge i_clk_sys);
    #1;
    o_rd_en = 1'b1;
    o_addr = a;
    @(posedge i_clk_sys);
    #1;
    o_rd_en = 1'b0;
  endtask : rd

  // Copy staged settings to active
  task automatic update();
    wr(csmc_pkg::ADDR_UPDATE, 8'h01);
  endtask : update

  // Power, polarity, pump mode and reference enables
  task automatic config_pll(input logic [7:0] p, input logic [7:0] r);
    wr(csmc_pkg::ADDR_PLL_CTRL, p);
    wr(csmc_pkg::ADDR_REF_EN, r);
  endtask : config_pll

  // Oscillator calibration, rearmed unless first after power-up
  task automatic calibrate(input logic first);
    if (!first) begin
      wr(csmc_pkg::ADDR_CAL_CTRL, 8'h00);
      update();
    end
    wr(csmc_pkg::ADDR_CAL_CTRL, 8'h01);
    update();
  endtask : calibrate
endmodule : csmc_host_model
`default_nettype wire

// ### tb/tb_clock_source_mode_config.sv
// Self-checking bench for the clock source mode configuration core.
// Assumes the host model drives the register port; reads are checked via a queue.
`timescale 1ns/10ps
`default_nettype none
module tb_clock_source_mode_config;
  // ==========================================================================
  // Signals
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_wr_en, i_rd_en, o_rd_valid, o_pll_normal, o_pll_power_down, o_pfd_negative;
  logic o_src_internal_osc, o_div_bypass, o_cal_start;
  logic [9:0] i_addr;
  logic [7:0] i_wdata, o_rdata, p, s, d, r, c0;
  logic [1:0] o_charge_pump_pin_mode;
  logic [2:0] o_ref_enable, o_osc_div_sel;
  logic [7:0] exp_q[$];
  logic [7:0] cal_cnt = 8'h00;
  logic [31:0] seed = 32'h00010229;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;

  always #2.5 i_clk_sys = ~i_clk_sys;

  csmc_host_model i_host (.i_clk_sys(i_clk_sys), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
    .o_addr(i_addr), .o_wdata(i_wdata));

  csmc_core i_dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .o_rd_valid(o_rd_valid), .o_pll_normal(o_pll_normal),
    .o_pll_power_down(o_pll_power_down), .o_pfd_negative(o_pfd_negative),
    .o_charge_pump_pin_mode(o_charge_pump_pin_mode), .o_ref_enable(o_ref_enable),
    .o_src_internal_osc(o_src_internal_osc), .o_div_bypass(o_div_bypass),
    .o_osc_div_sel(o_osc_div_sel), .o_cal_start(o_cal_start));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs

  task automatic print_verdict();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (compares > 0 && miscompares == 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Note the expected byte, then issue the read
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    i_host.rd(a);
  endtask : rd

  // All mode outputs against given register images
  task automatic chk_modes(input logic [7:0] pl, sr, dv, rf);
    chk({o_pll_normal, o_pll_power_down, o_pfd_negative, o_charge_pump_pin_mode,
      o_ref_enable}, {pl[1:0] == 2'h0, pl[1:0] == 2'h1, pl[7], pl[3:2], rf[2:0]});
    chk({3'h0, o_src_internal_osc, o_div_bypass, o_osc_div_sel},
      {3'h0, sr[1], sr[0], dv[2:0]});
  endtask : chk_modes

  // ==========================================================================
  // Output watcher: read data, calibration pulses, timeout
  always @(negedge i_clk_sys) begin
    cycles++;
    if (o_rd_valid === 1'b1) begin
      if (exp_q.size() > 0) begin
        chk(o_rdata, exp_q.pop_front());
      end else begin
        miscompares++;
        $display("BAD t=%0t got=%h exp=%h", $time, o_rdata, 8'h00);
      end
    end
    if (o_cal_start === 1'b1) begin
      cal_cnt <= cal_cnt + 8'h01;
    end
    if (cycles == 6000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge i_clk_sys);
    #1 i_sys_rst = 1'b0;
    repeat (10) @(posedge i_clk_sys);
    // Reset state of outputs and registers
    chk_modes(8'h01, 8'h00, 8'h00, 8'h00);
    rd(csmc_pkg::ADDR_PLL_CTRL, 8'h01);
    rd(csmc_pkg::ADDR_SRC_SEL, 8'h00);
    rd(csmc_pkg::ADDR_DIV_SET, 8'h00);
    rd(csmc_pkg::ADDR_CAL_CTRL, 8'h00);
    // Staged writes stay hidden until update
    i_host.wr(csmc_pkg::ADDR_PLL_CTRL, 8'h00);
    i_host.wr(csmc_pkg::ADDR_SRC_SEL, 8'h03);
    chk_modes(8'h01, 8'h00, 8'h00, 8'h00);
    rd(csmc_pkg::ADDR_SRC_SEL, 8'h03);
    i_host.update();
    chk_modes(8'h00, 8'h03, 8'h00, 8'h00);
    // Random mode settings
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      p = seed[7:0] & 8'h8f;
      s = seed[15:8] & 8'h03;
      d = seed[23:16] & 8'h07;
      r = seed[31:24] & 8'h07;
      i_host.config_pll(p, r);
      // Divider and bypass picks stand for a source the host keeps in range
      i_host.wr(csmc_pkg::ADDR_DIV_SET, d);
      i_host.wr(csmc_pkg::ADDR_SRC_SEL, s);
      i_host.update();
      chk_modes(p, s, d, r);
      rd(csmc_pkg::ADDR_PLL_CTRL, p);
      rd(csmc_pkg::ADDR_REF_EN, r);
    end
    // Calibration after PLL setup, then repeat without and with rearm
    c0 = cal_cnt;
    i_host.calibrate(1'b1);
    repeat (2) @(posedge i_clk_sys);
    chk(cal_cnt, c0 + 8'h01);
    i_host.update();
    repeat (2) @(posedge i_clk_sys);
    chk(cal_cnt, c0 + 8'h01);
    i_host.calibrate(1'b0);
    repeat (2) @(posedge i_clk_sys);
    chk(cal_cnt, c0 + 8'h02);
    // Unmapped and strobe-only places read as zero
    rd(10'h3ff, 8'h00);
    rd(csmc_pkg::ADDR_UPDATE, 8'h00);
    // Save, then power-up restore through a reset
    i_host.wr(csmc_pkg::ADDR_NV_CTRL, 8'h01);
    rd(csmc_pkg::ADDR_NV_CTRL, 8'h02);
    repeat (12) @(posedge i_clk_sys);
    rd(csmc_pkg::ADDR_NV_CTRL, 8'h00);
    repeat (3) @(posedge i_clk_sys);
    c0 = cal_cnt;
    #1 i_sys_rst = 1'b1;
    repeat (20) @(posedge i_clk_sys);
    #1 i_sys_rst = 1'b0;
    // Write landing with the restore pulse is dropped
    repeat (5) @(posedge i_clk_sys);
    i_host.wr(csmc_pkg::ADDR_PLL_CTRL, 8'h55);
    repeat (3) @(posedge i_clk_sys);
    chk_modes(p, s, d, r);
    chk(cal_cnt, c0 + 8'h01);
    rd(csmc_pkg::ADDR_PLL_CTRL, p);
    rd(csmc_pkg::ADDR_NV_CTRL, 8'h04);
    repeat (3) @(posedge i_clk_sys);
    chk(8'(exp_q.size()), 8'h00);
    print_verdict();
  end
endmodule : tb_clock_source_mode_config
`default_nettype wire
